// ===== bench/hnb_bridge_asserts.sv
// Concurrent checks on the bridge pins
`timescale 1ns/1ps
module hnb_bridge_asserts import hnb_pkg::*; (
    input wire logic                     sys_clk,
    input wire logic                     rst_b,
    input wire logic                     system_reset_drive,
    input wire logic                     narrow_cpu_reset_in,
    input wire logic                     host_cpu_reset_out,
    input wire hnb_strap_s               strap,
    input wire logic                     host_ready_n_o,
    input wire logic                     narrow_ready_n,
    input wire logic                     narrow_addr_strobe_n,
    input wire logic                     narrow_hold_req,
    input wire logic                     narrow_hold_ack_o,
    input wire logic                     narrow_bus_oe,
    input wire logic                     hold_req_or_addr_hold_o,
    input wire logic                     expansion_mem_write_n,
    input wire logic                     snoop_valid,
    input wire logic                     a20_block_n,
    input wire logic [NARROW_ADDR_W-1:0] narrow_address_bus,
    input wire hnb_cycdef_s              narrow_cycdef,
    input wire hnb_cycdef_s              host_cycdef
);
    logic [1:0] up_q;
    logic [1:0] up_d;
    always_comb begin
        up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) up_q <= 2'h0;
        else up_q <= up_d;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    cpu_rst_sync_a: assert property ((up_q == 2'h3) |-> host_cpu_reset_out == $past(narrow_cpu_reset_in, 2))
        else $error("cpu reset not synced");
    strap_hold_a: assert property (!system_reset_drive [*4] |=> $stable(strap))
        else $error("strap changed");
    async_clk_a: assert property (!strap.sync_mode |-> !strap.full_clock)
        else $error("full clock set in async mode");
    ready_cause_a: assert property ($fell(host_ready_n_o) |-> !$past(narrow_ready_n, 2))
        else $error("host ready without narrow ready");
    strobe_pulse_a: assert property (!narrow_addr_strobe_n |=> narrow_addr_strobe_n)
        else $error("narrow strobe longer than one cycle");
    release_bus_a: assert property (narrow_hold_ack_o |-> !narrow_bus_oe && narrow_addr_strobe_n)
        else $error("bus driven when released");
    ack_cause_a: assert property ($rose(narrow_hold_ack_o) |-> $past(narrow_hold_req))
        else $error("narrow hold ack without request");
    legacy_hold_a: assert property ($rose(narrow_hold_ack_o) && !strap.cache_mode |-> ##[0:2] hold_req_or_addr_hold_o)
        else $error("no legacy hold request");
    snoop_cap_a: assert property ($fell(expansion_mem_write_n) |-> ##[1:6] snoop_valid)
        else $error("snoop capture missing");
    a20_gate_a: assert property (!strap.cache_mode && !a20_block_n && !narrow_addr_strobe_n
        |-> !narrow_address_bus[A20_POS])
        else $error("address bit 20 not blocked");
    cycdef_copy_a: assert property (!narrow_addr_strobe_n |-> narrow_cycdef == host_cycdef)
        else $error("cycle definition not copied");
    strobe_c: cover property (!narrow_addr_strobe_n);
    hold_c: cover property ($rose(narrow_hold_ack_o));
    snoop_c: cover property (snoop_valid);
endmodule : hnb_bridge_asserts

bind hnb_bridge hnb_bridge_asserts chk_u (.*);

// ===== bench/hnb_bridge_tb_top.sv
// Self-checking bench for the host to narrow bus bridge
`timescale 1ns/1ps
module hnb_bridge_tb_top;
    import hnb_pkg::*;
    logic sys_clk, rst_b, system_reset_drive, hold_strap, narrow_hold_ack_i, host_ready_i, narrow_cpu_reset_in;
    logic host_addr_strobe_n, hold_ack_or_burst_last, a20_block_n, narrow_ready_n, narrow_hold_req;
    logic expansion_mem_write_n, invalidate_req, hold_req_or_addr_hold_i;
    hnb_cycdef_s host_cycdef, narrow_cycdef;
    hnb_strap_s strap;
    logic [3:0] host_byte_enables_n, wait_cycles;
    logic [29:0] host_addr_i, host_addr_o;
    logic [31:0] host_data_i, host_data_o;
    logic [15:0] narrow_data_i, narrow_data_o;
    logic [22:0] narrow_addr_i, narrow_address_bus, snoop_addr;
    logic host_cpu_reset_out, hold_req_or_addr_hold_o, hold_req_or_addr_hold_oe, host_ready_n_o, burst_ready_n;
    logic host_ready_oe, host_data_oe, host_addr_oe, narrow_data_oe, narrow_addr_strobe_n, narrow_bus_oe;
    logic narrow_low_byte_enable_n, narrow_high_byte_enable_n, narrow_hold_ack_o, snoop_valid;
    int num_errors = 0;
    int check_count = 0;
    assign hold_req_or_addr_hold_i = hold_strap;
    hnb_bridge dut_u (.*);
    hnb_partner far_u (.sys_clk, .rst_b, .narrow_addr_strobe_n, .narrow_address_bus, .wait_cycles,
        .hold_req(hold_req_or_addr_hold_o), .cache_mode(strap.cache_mode), .narrow_ready_n, .narrow_data_i,
        .hold_ack(hold_ack_or_burst_last));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic end_of_test;
        if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic set_straps(input logic s, input logic c, input logic f);
        @(posedge sys_clk);
        {narrow_hold_ack_i, hold_strap, host_ready_i} <= {s, c, f};
        system_reset_drive <= 1'b1;
        tick(3);
        system_reset_drive <= 1'b0;
        tick(4);
        chk("strap", strap, {s, c, s & f});
        {narrow_hold_ack_i, hold_strap, host_ready_i} <= {~s, ~c, ~f};
        tick(4);
        chk("strap kept", strap, {s, c, s & f});
    endtask : set_straps
    task automatic host_cycle(input logic wr, input logic [3:0] ben, input logic blk, input int nexp);
        logic [29:0] ad;
        logic [31:0] wd;
        logic [22:0] na;
        int nstb;
        int h;
        ad = 30'h2a5c3d1 + ben;
        wd = 32'hc3a51e96 ^ {8{ben}};
        nstb = 0;
        @(posedge sys_clk);
        host_addr_strobe_n <= 1'b0;
        host_cycdef <= '{write_read: wr, mem_io: 1'b1, data_ctrl: 1'b1};
        {host_byte_enables_n, host_addr_i, host_data_i, a20_block_n} <= {ben, ad, wd, blk};
        tick(1);
        host_addr_strobe_n <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            tick(1);
            if (!narrow_addr_strobe_n) begin
                h = (nstb == 0 && ben[1:0] != 2'b11) ? 0 : 1;
                na = {ad[21:0], h[0]};
                if (!blk) na[A20_POS] = 1'b0;
                chk("narrow addr", narrow_address_bus, na);
                chk("narrow ble", narrow_low_byte_enable_n, ben[2*h]);
                chk("narrow bhe", narrow_high_byte_enable_n, ben[2*h+1]);
                chk("narrow cycdef", narrow_cycdef, {wr, 2'b11});
                if (wr) chk("narrow wdata", {narrow_data_oe, narrow_data_o}, {1'b1, wd[16*h+:16]});
                nstb++;
            end
            if (!host_ready_n_o) break;
        end
        chk("host ready", host_ready_n_o, 1'b0);
        chk("narrow cycles", nstb, nexp);
        if (!wr && ben[3:2] != 2'b11) chk("host rdata", host_data_o[31:16], {ad[14:0], 1'b1} ^ 16'h5a5a);
        if (!wr && ben[1:0] != 2'b11) chk("host rdata", host_data_o[15:0], {ad[14:0], 1'b0} ^ 16'h5a5a);
    endtask : host_cycle
    task automatic cpu_reset_path;
        narrow_cpu_reset_in <= 1'b1;
        tick(3);
        chk("cpu reset", host_cpu_reset_out, 1'b1);
        chk("strap untouched", strap, 3'b101);
        narrow_cpu_reset_in <= 1'b0;
        tick(3);
        chk("cpu reset", host_cpu_reset_out, 1'b0);
    endtask : cpu_reset_path
    task automatic narrow_handover;
        narrow_hold_req <= 1'b1;
        for (int i = 0; i < 8 && narrow_hold_ack_o !== 1'b1; i++) tick(1);
        tick(2);
        chk("narrow ack", {narrow_hold_ack_o, narrow_bus_oe}, 2'b10);
        chk("host hold", {hold_req_or_addr_hold_o, hold_ack_or_burst_last}, 2'b11);
        narrow_hold_req <= 1'b0;
        tick(6);
        chk("narrow ack off", narrow_hold_ack_o, 1'b0);
    endtask : narrow_handover
    task automatic snoop_capture;
        narrow_addr_i <= 23'h5b3c71;
        expansion_mem_write_n <= 1'b0;
        for (int i = 0; i < 8 && snoop_valid !== 1'b1; i++) tick(1);
        chk("snoop addr", {snoop_valid, snoop_addr}, {1'b1, 23'h5b3c71});
        expansion_mem_write_n <= 1'b1;
        tick(2);
    endtask : snoop_capture
    task automatic invalidate_hold;
        set_straps(1'b0, 1'b1, 1'b1);
        invalidate_req <= 1'b1;
        for (int i = 0; i < 8 && hold_req_or_addr_hold_o !== 1'b1; i++) tick(1);
        chk("address hold", hold_req_or_addr_hold_o, 1'b1);
        invalidate_req <= 1'b0;
    endtask : invalidate_hold
    initial begin
        {rst_b, hold_strap, host_ready_i, narrow_cpu_reset_in, narrow_hold_req, invalidate_req} = '0;
        {system_reset_drive, narrow_hold_ack_i, host_addr_strobe_n, a20_block_n, expansion_mem_write_n} = '1;
        {host_cycdef, host_byte_enables_n, host_addr_i, host_data_i, narrow_addr_i} = '0;
        wait_cycles = 4'h0;
        tick(8);
        rst_b <= 1'b1;
        set_straps(1'b0, 1'b0, 1'b1);
        set_straps(1'b1, 1'b0, 1'b1);
        host_cycle(1'b1, 4'h0, 1'b1, 2);
        wait_cycles <= 4'h3;
        host_cycle(1'b0, 4'h3, 1'b1, 1);
        host_cycle(1'b0, 4'h0, 1'b0, 2);
        host_cycle(1'b1, 4'hc, 1'b0, 1);
        cpu_reset_path();
        narrow_handover();
        snoop_capture();
        invalidate_hold();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        end_of_test();
    end
endmodule : hnb_bridge_tb_top

// ===== bench/hnb_partner.sv
// Far side model: narrow bus target and host hold handshake
`timescale 1ns/1ps
module hnb_partner (
    input  wire logic                              sys_clk,
    input  wire logic                              rst_b,
    input  wire logic                              narrow_addr_strobe_n,
    input  wire logic [hnb_pkg::NARROW_ADDR_W-1:0] narrow_address_bus,
    input  wire logic [3:0]                        wait_cycles,
    input  wire logic                              hold_req,
    input  wire logic                              cache_mode,
    output logic                                   narrow_ready_n,
    output logic [hnb_pkg::NARROW_DATA_W-1:0]      narrow_data_i,
    output logic                                   hold_ack
);
    logic [3:0]  cnt_q;
    logic        busy_q;
    logic [15:0] word_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            {cnt_q, busy_q, word_q, hold_ack, narrow_data_i} <= '0;
            narrow_ready_n <= 1'b1;
        end else begin
            narrow_ready_n <= 1'b1;
            // Released data bus toggles so stale values never match
            narrow_data_i <= ~narrow_data_i;
            hold_ack <= hold_req && !cache_mode;
            if (!narrow_addr_strobe_n) begin
                busy_q <= 1'b1;
                cnt_q <= wait_cycles;
                word_q <= narrow_address_bus[15:0] ^ 16'h5a5a;
            end else if (busy_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (busy_q) begin
                busy_q <= 1'b0;
                narrow_ready_n <= 1'b0;
                narrow_data_i <= word_q;
            end
        end
    end
endmodule : hnb_partner

// ===== pkg/hnb_pkg.sv
// Package: constants and carriers for the host to narrow bus bridge
package hnb_pkg;
    localparam int HOST_DATA_W   = 32;
    localparam int NARROW_DATA_W = 16;
    localparam int HOST_ADDR_W   = 30;
    localparam int NARROW_ADDR_W = 23;
    localparam int BE_W          = 4;
    localparam int SYNC_STAGES   = 2;
    localparam int A20_POS       = 19;
    localparam int SNOOP_DEPTH   = 4;
    localparam int SNOOP_AW      = 2;
    localparam logic STRAP_SYNC_RST    = 1'b0;
    localparam logic STRAP_CACHE_RST   = 1'b0;
    localparam logic STRAP_FULLCLK_RST = 1'b0;
    localparam logic [BE_W-1:0] BE_NONE = 4'hf;

    typedef struct packed {
        logic write_read;
        logic mem_io;
        logic data_ctrl;
    } hnb_cycdef_s;

    typedef struct packed {
        logic sync_mode;
        logic cache_mode;
        logic full_clock;
    } hnb_strap_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_LOW, ST_WAIT_LOW, ST_HIGH, ST_WAIT_HIGH, ST_DONE, ST_RELEASED
    } hnb_state_e;
endpackage : hnb_pkg

// ===== rtl/hnb_bridge.sv
// Host to narrow bus bridge: pin-level cycle translation, arbitration, straps
// Notes on behaviour
// - System reset fall latches narrow hold ack pin: high is synchronous.
// - System reset fall latches hold pin: high is cache mode.
// - Synchronous mode: ready strap picks full or half narrow clock.
// - Host cpu reset is narrow cpu reset synchronised.
// - Narrow cpu reset resets only the host cpu.
// - Cache mode: burst ready ends the cycle; burst last is not sampled.
// - Legacy mode: hold request while host bus is needed.
// - Cache mode: address hold for invalidation cycles.
// - Expansion memory write captures narrow address for snooping.
// - Narrow hold request: release bus, assert narrow hold ack.
// - Narrow strobe on valid cycle; wait for narrow ready.
// - Legacy mode: non-burst ready on host cycle completion.
// - Host cycle definition copied to narrow side.
// - Host byte enables mapped to narrow byte enables.
// - Data passes host to narrow on writes, back on reads.
// - Host address bits 31, 24..2; narrow bits 23..1.
// - Legacy mode: a20 block low forces address bit 20 low.
`timescale 1ns/1ps
module hnb_bridge (
    input  wire logic                              sys_clk,
    input  wire logic                              rst_b,
    input  wire logic                              system_reset_drive,
    input  wire logic                              hold_req_or_addr_hold_i,
    input  wire logic                              narrow_hold_ack_i,
    input  wire logic                              host_ready_i,
    input  wire logic                              narrow_cpu_reset_in,
    input  wire logic                              host_addr_strobe_n,
    input  wire hnb_pkg::hnb_cycdef_s              host_cycdef,
    input  wire logic [hnb_pkg::BE_W-1:0]          host_byte_enables_n,
    input  wire logic [hnb_pkg::HOST_ADDR_W-1:0]   host_addr_i,
    input  wire logic [hnb_pkg::HOST_DATA_W-1:0]   host_data_i,
    input  wire logic                              hold_ack_or_burst_last,
    input  wire logic                              a20_block_n,
    input  wire logic                              narrow_ready_n,
    input  wire logic                              narrow_hold_req,
    input  wire logic [hnb_pkg::NARROW_DATA_W-1:0] narrow_data_i,
    input  wire logic                              expansion_mem_write_n,
    input  wire logic [hnb_pkg::NARROW_ADDR_W-1:0] narrow_addr_i,
    input  wire logic                              invalidate_req,
    output hnb_pkg::hnb_strap_s                    strap,
    output logic                                   host_cpu_reset_out,
    output logic                                   hold_req_or_addr_hold_o,
    output logic                                   hold_req_or_addr_hold_oe,
    output logic                                   host_ready_n_o,
    output logic                                   burst_ready_n,
    output logic                                   host_ready_oe,
    output logic [hnb_pkg::HOST_DATA_W-1:0]        host_data_o,
    output logic                                   host_data_oe,
    output logic [hnb_pkg::HOST_ADDR_W-1:0]        host_addr_o,
    output logic                                   host_addr_oe,
    output logic [hnb_pkg::NARROW_ADDR_W-1:0]      narrow_address_bus,
    output logic [hnb_pkg::NARROW_DATA_W-1:0]      narrow_data_o,
    output logic                                   narrow_data_oe,
    output logic                                   narrow_addr_strobe_n,
    output hnb_pkg::hnb_cycdef_s                   narrow_cycdef,
    output logic                                   narrow_low_byte_enable_n,
    output logic                                   narrow_high_byte_enable_n,
    output logic                                   narrow_bus_oe,
    output logic                                   narrow_hold_ack_o,
    output logic                                   snoop_valid,
    output logic [hnb_pkg::NARROW_ADDR_W-1:0]      snoop_addr
);
    import hnb_pkg::*;

    // Host address bus index 0 is byte address bit 2, index 22 is bit 24, index 29 is bit 31
    localparam int HA_A20 = 18;

    // Byte pair is live when either byte enable is low
    function automatic logic pair_live(input logic [1:0] be_n);
        pair_live = ~&be_n;
    endfunction : pair_live

    // Strap capture
    hnb_strap_s strap_q;
    hnb_strap_s strap_d;
    logic       rst_drv_q;
    logic       rst_drv_d;

    always_comb begin
        rst_drv_d = system_reset_drive;
        strap_d   = strap_q;
        if (rst_drv_q && !system_reset_drive) begin
            strap_d.sync_mode  = narrow_hold_ack_i;
            strap_d.cache_mode = hold_req_or_addr_hold_i;
            strap_d.full_clock = narrow_hold_ack_i ? host_ready_i : 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_drv_q <= 1'b0;
            strap_q   <= '{STRAP_SYNC_RST, STRAP_CACHE_RST, STRAP_FULLCLK_RST};
        end else begin
            rst_drv_q <= rst_drv_d;
            strap_q   <= strap_d;
        end
    end

    assign strap = strap_q;

    // Host reset resynchronised; feeds nothing but the pin
    hnb_sync u_rst_sync (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .din     (narrow_cpu_reset_in),
        .dout    (host_cpu_reset_out)
    );

    // Snoop capture
    logic [SNOOP_AW-1:0]      wr_idx_q;
    logic [SNOOP_AW-1:0]      wr_idx_d;
    logic [SNOOP_AW-1:0]      rd_idx_q;
    logic [SNOOP_AW-1:0]      rd_idx_d;
    logic                     expansion_mem_write_n_q;
    logic                     expansion_mem_write_n_d;
    logic                     capture;
    logic                     pend_q;
    logic                     pend_d;
    logic                     snoop_valid_q;
    logic                     snoop_valid_d;
    logic [NARROW_ADDR_W-1:0] mem_rd;
    logic [SNOOP_AW-1:0]      rd_sel;

    assign capture = !expansion_mem_write_n && !expansion_mem_write_n_q;
    // Entry being issued, so read data line up with snoop_valid
    assign rd_sel  = rd_idx_q - SNOOP_AW'(pend_q);

    always_comb begin
        expansion_mem_write_n_d        = !expansion_mem_write_n;
        wr_idx_d      = wr_idx_q;
        rd_idx_d      = rd_idx_q;
        pend_d        = pend_q;
        snoop_valid_d = 1'b0;
        if (capture) begin
            wr_idx_d = wr_idx_q + 1'b1;
        end
        if (pend_q) begin
            snoop_valid_d = 1'b1;
            pend_d        = 1'b0;
        end else if (rd_idx_q != wr_idx_q) begin
            rd_idx_d = rd_idx_q + 1'b1;
            pend_d   = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            expansion_mem_write_n_q        <= 1'b0;
            wr_idx_q      <= '0;
            rd_idx_q      <= '0;
            pend_q        <= 1'b0;
            snoop_valid_q <= 1'b0;
        end else begin
            expansion_mem_write_n_q        <= expansion_mem_write_n_d;
            wr_idx_q      <= wr_idx_d;
            rd_idx_q      <= rd_idx_d;
            pend_q        <= pend_d;
            snoop_valid_q <= snoop_valid_d;
        end
    end

    hnb_snoop_mem u_snoop (
        .sys_clk (sys_clk),
        .wr_en   (capture),
        .wr_idx  (wr_idx_q),
        .wr_data (narrow_addr_i),
        .rd_idx  (rd_sel),
        .rd_data (mem_rd)
    );

    assign snoop_valid = snoop_valid_q;
    assign snoop_addr  = mem_rd;

    // Cycle engine
    hnb_state_e               st_q;
    hnb_state_e               st_d;
    hnb_cycdef_s              cyc_q;
    hnb_cycdef_s              cyc_d;
    logic [BE_W-1:0]          be_q;
    logic [BE_W-1:0]          be_d;
    logic [HOST_ADDR_W-1:0]   addr_q;
    logic [HOST_ADDR_W-1:0]   addr_d;
    logic [HOST_DATA_W-1:0]   data_q;
    logic [HOST_DATA_W-1:0]   data_d;
    logic                     ads_q;
    logic                     ads_d;
    logic                     rdy_q;
    logic                     rdy_d;
    logic                     burst_ready_n_q;
    logic                     burst_ready_n_d;
    logic                     hldout_q;
    logic                     hldout_d;
    logic                     hack_q;
    logic                     hack_d;
    logic                     dsel_q;
    logic                     dsel_d;
    logic                     burst_q;
    logic                     burst_d;
    logic [NARROW_ADDR_W-1:0] naddr;
    logic                     a20_gate;

    // narrow word address built from host bits 23..2 plus the half select
    assign a20_gate = strap_q.cache_mode | a20_block_n;
    always_comb begin
        naddr         = {addr_q[21:0], dsel_q};
        naddr[A20_POS] = addr_q[HA_A20] & a20_gate;
    end

    always_comb begin
        st_d     = st_q;
        cyc_d    = cyc_q;
        be_d     = be_q;
        addr_d   = addr_q;
        data_d   = data_q;
        ads_d    = 1'b1;
        rdy_d    = 1'b1;
        burst_ready_n_d   = 1'b1;
        dsel_d   = dsel_q;
        burst_d  = burst_q;
        hack_d   = hack_q;
        hldout_d = strap_q.cache_mode ? invalidate_req : 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (narrow_hold_req) begin
                    st_d   = ST_RELEASED;
                    hack_d = 1'b1;
                end else if (!host_addr_strobe_n) begin
                    cyc_d   = host_cycdef;
                    be_d    = host_byte_enables_n;
                    addr_d  = host_addr_i;
                    data_d  = host_data_i;
                    burst_d = strap_q.cache_mode;
                    if (pair_live(host_byte_enables_n[1:0]) || !pair_live(host_byte_enables_n[3:2])) begin
                        st_d   = ST_LOW;
                        dsel_d = 1'b0;
                    end else begin
                        st_d   = ST_HIGH;
                        dsel_d = 1'b1;
                    end
                end
            end
            ST_LOW: begin
                ads_d = 1'b0;
                st_d  = ST_WAIT_LOW;
            end
            ST_WAIT_LOW: begin
                if (!narrow_ready_n) begin
                    if (!cyc_q.write_read) begin
                        data_d[15:0] = narrow_data_i;
                    end
                    if (pair_live(be_q[3:2])) begin
                        st_d   = ST_HIGH;
                        dsel_d = 1'b1;
                    end else begin
                        st_d = ST_DONE;
                    end
                end
            end
            ST_HIGH: begin
                ads_d = 1'b0;
                st_d  = ST_WAIT_HIGH;
            end
            ST_WAIT_HIGH: begin
                if (!narrow_ready_n) begin
                    if (!cyc_q.write_read) begin
                        data_d[31:16] = narrow_data_i;
                    end
                    st_d = ST_DONE;
                end
            end
            ST_DONE: begin
                if (burst_q) begin
                    burst_ready_n_d = 1'b0;
                end else begin
                    rdy_d = 1'b0;
                end
                st_d = ST_IDLE;
            end
            ST_RELEASED: begin
                if (!narrow_hold_req) begin
                    hack_d = 1'b0;
                    st_d   = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        // Legacy mode: ask for the host bus while narrow master owns memory
        if (!strap_q.cache_mode && st_d == ST_RELEASED) begin
            hldout_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q     <= ST_IDLE;
            cyc_q    <= '0;
            be_q     <= BE_NONE;
            addr_q   <= '0;
            data_q   <= '0;
            ads_q    <= 1'b1;
            rdy_q    <= 1'b1;
            burst_ready_n_q   <= 1'b1;
            hldout_q <= 1'b0;
            hack_q   <= 1'b0;
            dsel_q   <= 1'b0;
            burst_q  <= 1'b0;
        end else begin
            st_q     <= st_d;
            cyc_q    <= cyc_d;
            be_q     <= be_d;
            addr_q   <= addr_d;
            data_q   <= data_d;
            ads_q    <= ads_d;
            rdy_q    <= rdy_d;
            burst_ready_n_q   <= burst_ready_n_d;
            hldout_q <= hldout_d;
            hack_q   <= hack_d;
            dsel_q   <= dsel_d;
            burst_q  <= burst_d;
        end
    end

    // Output registers
    logic [NARROW_ADDR_W-1:0] naddr_q;
    logic                     nble_q;
    logic                     nbhe_q;
    logic                     ndoe_q;
    logic                     hdoe_q;
    logic                     haoe_q;
    logic                     noe_q;
    logic [NARROW_DATA_W-1:0] ndata_q;
    logic                     granted;

    // in legacy mode host hold ack grants the host bus to the bridge
    assign granted = !strap_q.cache_mode && hldout_q && hold_ack_or_burst_last;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            naddr_q <= '0;
            nble_q  <= 1'b1;
            nbhe_q  <= 1'b1;
            ndoe_q  <= 1'b0;
            hdoe_q  <= 1'b0;
            haoe_q  <= 1'b0;
            noe_q   <= 1'b0;
            ndata_q <= '0;
        end else begin
            naddr_q <= naddr;
            nble_q  <= dsel_d ? be_d[2] : be_d[0];
            nbhe_q  <= dsel_d ? be_d[3] : be_d[1];
            ndata_q <= dsel_d ? data_d[31:16] : data_d[15:0];
            ndoe_q  <= cyc_d.write_read && st_d inside {ST_LOW, ST_WAIT_LOW, ST_HIGH, ST_WAIT_HIGH};
            noe_q   <= st_d != ST_RELEASED;
            hdoe_q  <= !cyc_d.write_read && st_d == ST_DONE;
            haoe_q  <= granted || (strap_q.cache_mode && hldout_d);
        end
    end

    assign hold_req_or_addr_hold_o  = hldout_q;
    assign hold_req_or_addr_hold_oe = 1'b1;
    assign host_ready_n_o           = rdy_q;
    assign burst_ready_n            = burst_ready_n_q;
    assign host_ready_oe            = rst_drv_q ? 1'b0 : 1'b1;
    assign host_data_o              = data_q;
    assign host_data_oe             = hdoe_q;
    assign host_addr_o              = addr_q;
    assign host_addr_oe             = haoe_q;
    assign narrow_address_bus       = naddr_q;
    assign narrow_data_o            = ndata_q;
    assign narrow_data_oe           = ndoe_q;
    assign narrow_addr_strobe_n     = ads_q;
    assign narrow_cycdef            = cyc_q;
    assign narrow_low_byte_enable_n = nble_q;
    assign narrow_high_byte_enable_n = nbhe_q;
    assign narrow_bus_oe            = noe_q;
    assign narrow_hold_ack_o        = hack_q;
endmodule : hnb_bridge

// ===== rtl/hnb_snoop_mem.sv
// Small store of captured snoop addresses with registered read
`timescale 1ns/1ps
module hnb_snoop_mem (
    input  wire logic                                sys_clk,
    input  wire logic                                wr_en,
    input  wire logic [hnb_pkg::SNOOP_AW-1:0]        wr_idx,
    input  wire logic [hnb_pkg::NARROW_ADDR_W-1:0]   wr_data,
    input  wire logic [hnb_pkg::SNOOP_AW-1:0]        rd_idx,
    output logic      [hnb_pkg::NARROW_ADDR_W-1:0]   rd_data
);
    import hnb_pkg::*;
    logic [NARROW_ADDR_W-1:0] mem_q [SNOOP_DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
        rd_data <= mem_q[rd_idx];
    end
endmodule : hnb_snoop_mem

// ===== rtl/hnb_sync.sv
// Two-stage synchroniser for the narrow cpu reset
`timescale 1ns/1ps
module hnb_sync (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic din,
    output logic      dout
);
    import hnb_pkg::*;
    logic [SYNC_STAGES-1:0] pipe_q;
    logic [SYNC_STAGES-1:0] pipe_d;

    always_comb begin
        pipe_d = {pipe_q[SYNC_STAGES-2:0], din};
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pipe_q <= '0;
        end else begin
            pipe_q <= pipe_d;
        end
    end

    assign dout = pipe_q[SYNC_STAGES-1];
endmodule : hnb_sync
